// [rtl/rtcc_ctrl.v]
// Notes on behaviour
// - frequency output drives the shared pin when enabled in register 08h
// - a 1 Hz choice exists among frequency output settings
// - compensation is off after power-up until the host enables it
// - factory step trim loads into low five bits of 0Dh at power-up
// - bit 7 of 0Dh enables sensing; on main supply correct every 60 s
// - bits 5 and 6 of 0Dh pick battery-mode compensation behaviour
// - a 0Dh write with enable set starts a compensation cycle at once, or after the one in progress ends; writes during one cycle queue only one more
// - final trims load the factory initial trim at power-up, then only on the first reading or when temperature differs from previous reading
// - higher analog trim means more capacitance and lower frequency
// - new reading every 60 s on supply, up to ten minutes on battery
`include "rtcc_defs.vh"
`default_nettype none

module rtcc_ctrl (
   input  wire       i_clock,
   input  wire       i_reset_n,
   input  wire       i_scl,
   input  wire       i_sda,
   output reg        o_sda_out,
   output reg        o_sda_oe,
   input  wire       i_osc_32k,
   input  wire       i_battery_mode,
   input  wire [4:0] i_factory_step_trim,
   input  wire [7:0] i_factory_initial_trim,
   input  wire [7:0] i_factory_curvature,
   input  wire       i_temp_valid,
   input  wire [9:0] i_temp_code,
   output reg        o_conv_start,
   output reg  [5:0] o_final_analog_trim,
   output reg  [2:0] o_final_digital_trim,
   output reg        o_irq_or_freq_out_pin_out,
   output reg        o_irq_or_freq_out_pin_oe
);
   localparam [6:0] S_IDLE = 7'h01;
   localparam [6:0] S_ADDR = 7'h02;
   localparam [6:0] S_AACK = 7'h04;
   localparam [6:0] S_WR   = 7'h08;
   localparam [6:0] S_WACK = 7'h10;
   localparam [6:0] S_RD   = 7'h20;
   localparam [6:0] S_MACK = 7'h40;
   localparam [2:0] C_IDLE = 3'h1;
   localparam [2:0] C_CONV = 3'h2;
   localparam [2:0] C_CALC = 3'h4;

   wire       scl_s, sda_s, osc_s, bat_s;
   reg        scl_p_q, sda_p_q, osc_p_q;
   rtcc_sync #(.WIDTH(4)) u_sync (
      .i_clock   (i_clock),
      .i_reset_n (i_reset_n),
      .i_async   ({i_scl, i_sda, i_osc_32k, i_battery_mode}),
      .o_sync    ({scl_s, sda_s, osc_s, bat_s})
   );
   wire scl_rise = scl_s & ~scl_p_q;
   wire scl_fall = ~scl_s & scl_p_q;
   wire i2c_start = scl_s & scl_p_q & sda_p_q & ~sda_s;
   wire i2c_stop  = scl_s & scl_p_q & ~sda_p_q & sda_s;
   wire osc_rise  = osc_s & ~osc_p_q;
   reg  [7:0] intctl_q;
   reg  [7:0] initrim_q;
   reg  [7:0] curve_q;
   reg  [7:0] compctl_q;
   reg        recall_q;
   reg  [6:0] st_q;
   reg  [3:0] bit_q;
   reg  [7:0] shift_q;
   reg  [7:0] ptr_q;
   reg        ptr_phase_q;
   reg        rw_q;
   reg        nack_q;
   reg        wr_tse_q;
   reg  [`RTCC_DIV_W-1:0]  div_q;
   reg  [`RTCC_SEC_W-1:0]  sec_q;
   reg  [`RTCC_SEC_W-1:0]  period;
   reg                     periodic_on;
   reg  [2:0]              cst_q;
   reg                     pend_q;
   reg  [9:0]              temp_q;
   reg  [9:0]              prev_q;
   reg                     have_prev_q;
   // read decode, also used when a read pointer walks
   function [7:0] rd_byte;
      input [7:0] addr;
      begin
         case (addr)
            `RTCC_ADDR_INTCTL:  rd_byte = intctl_q;
            `RTCC_ADDR_INITRIM: rd_byte = initrim_q;
            `RTCC_ADDR_CURVE:   rd_byte = curve_q;
            `RTCC_ADDR_COMPCTL: rd_byte = compctl_q;
            default:            rd_byte = 8'h00;
         endcase
      end
   endfunction

   wire write_now = (st_q == S_WR) && scl_fall && (bit_q == 4'h8) && !ptr_phase_q;
   wire [7:0] rd_now = rd_byte(ptr_q);
   // serial slave
   always @(posedge i_clock or negedge i_reset_n) begin
      if (!i_reset_n) begin
         scl_p_q     <= 1'b1;
         sda_p_q     <= 1'b1;
         st_q        <= S_IDLE;
         bit_q       <= 4'h0;
         shift_q     <= 8'h00;
         ptr_q       <= 8'h00;
         ptr_phase_q <= 1'b0;
         rw_q        <= 1'b0;
         nack_q      <= 1'b0;
         o_sda_oe    <= 1'b0;
         o_sda_out   <= 1'b0;
      end else begin
         scl_p_q   <= scl_s;
         sda_p_q   <= sda_s;
         o_sda_out <= 1'b0;
         if (i2c_start) begin
            st_q        <= S_ADDR;
            bit_q       <= 4'h0;
            ptr_phase_q <= 1'b1;
            o_sda_oe    <= 1'b0;
         end else if (i2c_stop) begin
            st_q     <= S_IDLE;
            o_sda_oe <= 1'b0;
         end else begin
            case (st_q)
               S_IDLE: o_sda_oe <= 1'b0;
               S_ADDR, S_WR: begin
                  if (scl_rise) begin
                     shift_q <= {shift_q[6:0], sda_s};
                     bit_q   <= bit_q + 4'h1;
                  end else if (scl_fall && bit_q == 4'h8) begin
                     if (st_q == S_ADDR) begin
                        if (shift_q[7:1] == `RTCC_DEV_ADDR) begin
                           rw_q     <= shift_q[0];
                           o_sda_oe <= 1'b1;
                           st_q     <= S_AACK;
                        end else begin
                           st_q <= S_IDLE;
                        end
                     end else begin
                        ptr_q       <= ptr_phase_q ? shift_q : ptr_q + 8'h01;
                        ptr_phase_q <= 1'b0;
                        o_sda_oe <= 1'b1;
                        st_q     <= S_WACK;
                     end
                  end
               end
               S_AACK, S_WACK: begin
                  if (scl_fall) begin
                     bit_q <= 4'h0;
                     if (st_q == S_AACK && rw_q) begin
                        shift_q  <= rd_now;
                        ptr_q    <= ptr_q + 8'h01;
                        o_sda_oe <= ~rd_now[7];
                        st_q     <= S_RD;
                     end else begin
                        o_sda_oe <= 1'b0;
                        st_q     <= S_WR;
                     end
                  end
               end
               S_RD: begin
                  if (scl_fall) begin
                     bit_q <= bit_q + 4'h1;
                     if (bit_q == 4'h7) begin
                        o_sda_oe <= 1'b0;
                        st_q     <= S_MACK;
                     end else begin
                        shift_q  <= {shift_q[6:0], 1'b0};
                        o_sda_oe <= ~shift_q[6];
                     end
                  end
               end
               S_MACK: begin
                  if (scl_rise) begin
                     nack_q <= sda_s;
                  end else if (scl_fall) begin
                     if (nack_q) begin
                        st_q <= S_IDLE;
                     end else begin
                        bit_q    <= 4'h0;
                        shift_q  <= rd_now;
                        ptr_q    <= ptr_q + 8'h01;
                        o_sda_oe <= ~rd_now[7];
                        st_q     <= S_RD;
                     end
                  end
               end
               default: begin
                  st_q     <= S_IDLE;
                  o_sda_oe <= 1'b0;
               end
            endcase
         end
      end
   end
   // register file with power-up recall
   always @(posedge i_clock or negedge i_reset_n) begin
      if (!i_reset_n) begin
         recall_q  <= 1'b1;
         intctl_q  <= `RTCC_INTCTL_RST;
         initrim_q <= `RTCC_REG_RST;
         curve_q   <= `RTCC_REG_RST;
         compctl_q <= `RTCC_REG_RST;
         wr_tse_q  <= 1'b0;
      end else begin
         recall_q <= 1'b0;
         wr_tse_q <= 1'b0;
         if (recall_q) begin
            compctl_q <= {3'b000, i_factory_step_trim};
            initrim_q <= i_factory_initial_trim;
            curve_q   <= i_factory_curvature;
         end else if (write_now) begin
            case (ptr_q)
               `RTCC_ADDR_INTCTL:  intctl_q  <= shift_q;
               `RTCC_ADDR_INITRIM: initrim_q <= shift_q;
               `RTCC_ADDR_CURVE:   curve_q   <= shift_q;
               `RTCC_ADDR_COMPCTL: begin
                  compctl_q <= shift_q;
                  wr_tse_q  <= shift_q[`RTCC_TSE_BIT];
               end
               default: ;
            endcase
         end
      end
   end
   // interval selection
   always @* begin
      period      = `RTCC_MAIN_PERIOD_S;
      periodic_on = compctl_q[`RTCC_TSE_BIT];
      if (bat_s) begin
         case (compctl_q[`RTCC_BATSEL_HI:`RTCC_BATSEL_LO])
            2'b01:   period = `RTCC_BAT1_PERIOD_S;
            2'b10:   period = `RTCC_BAT2_PERIOD_S;
            2'b11:   period = `RTCC_BAT3_PERIOD_S;
            default: periodic_on = 1'b0;
         endcase
      end
   end
   wire sec_tick = osc_rise && (div_q == {`RTCC_DIV_W{1'b1}});
   wire periodic_go = sec_tick && periodic_on && (sec_q + 10'h001 >= period);
   // trim arithmetic
   reg [9:0]  diff;
   reg [19:0] sq;
   reg [27:0] prod;
   reg [12:0] scaled;
   reg [8:0]  step;
   reg [8:0]  base;
   reg [8:0]  trim_res;
   always @* begin
      diff     = (temp_q >= `RTCC_T0_CODE) ? temp_q - `RTCC_T0_CODE
                                           : `RTCC_T0_CODE - temp_q;
      sq       = diff * diff;
      prod     = sq * curve_q;
      scaled   = prod[27:20] * compctl_q[`RTCC_STEP_MSB:0];
      step     = scaled[12:4];
      base     = {1'b0, initrim_q};
      trim_res = (base >= step) ? base - step : 9'h000;
   end
   // divider, seconds and compensation sequencer
   always @(posedge i_clock or negedge i_reset_n) begin
      if (!i_reset_n) begin
         osc_p_q              <= 1'b0;
         div_q                <= {`RTCC_DIV_W{1'b0}};
         sec_q                <= {`RTCC_SEC_W{1'b0}};
         cst_q                <= C_IDLE;
         pend_q               <= 1'b0;
         temp_q               <= 10'h000;
         prev_q               <= 10'h000;
         have_prev_q          <= 1'b0;
         o_conv_start         <= 1'b0;
         o_final_analog_trim  <= 6'h00;
         o_final_digital_trim <= 3'h0;
      end else begin
         osc_p_q      <= osc_s;
         o_conv_start <= 1'b0;
         if (osc_rise) div_q <= div_q + 1'b1;
         if (wr_tse_q || periodic_go) begin
            sec_q <= {`RTCC_SEC_W{1'b0}};
         end else if (sec_tick) begin
            sec_q <= sec_q + 10'h001;
         end
         if (recall_q) begin
            o_final_analog_trim  <= i_factory_initial_trim[`RTCC_IAT_MSB:0];
            o_final_digital_trim <= {1'b0, i_factory_initial_trim[7:`RTCC_IDT_LSB]};
         end
         if ((wr_tse_q || periodic_go) && cst_q != C_IDLE) pend_q <= 1'b1;
         case (cst_q)
            C_IDLE: begin
               if (wr_tse_q || periodic_go || pend_q) begin
                  o_conv_start <= 1'b1;
                  pend_q       <= 1'b0;
                  cst_q        <= C_CONV;
               end
            end
            C_CONV: begin
               if (i_temp_valid) begin
                  temp_q <= i_temp_code;
                  cst_q  <= C_CALC;
               end
            end
            C_CALC: begin
               if (!have_prev_q || temp_q != prev_q) begin
                  o_final_analog_trim  <= trim_res[5:0];
                  o_final_digital_trim <= trim_res[8:6];
               end
               prev_q      <= temp_q;
               have_prev_q <= 1'b1;
               cst_q       <= C_IDLE;
            end
            default: cst_q <= C_IDLE;
         endcase
      end
   end
   // frequency output on open-drain pin
   wire [2:0] fsel = intctl_q[`RTCC_FSEL_MSB:0];
   wire       fout_bit = div_q[`RTCC_ONE_HZ_BIT - fsel];
   always @(posedge i_clock or negedge i_reset_n) begin
      if (!i_reset_n) begin
         o_irq_or_freq_out_pin_out <= 1'b0;
         o_irq_or_freq_out_pin_oe  <= 1'b0;
      end else begin
         o_irq_or_freq_out_pin_out <= 1'b0;
         o_irq_or_freq_out_pin_oe  <= intctl_q[`RTCC_FOUT_EN_BIT] & ~fout_bit;
      end
   end
endmodule // rtcc_ctrl

`default_nettype wire

// [rtl/rtcc_defs.vh]
`ifndef RTCC_DEFS_VH
`define RTCC_DEFS_VH

// register offsets
`define RTCC_ADDR_INTCTL    8'h08
`define RTCC_ADDR_INITRIM   8'h0B
`define RTCC_ADDR_CURVE     8'h0C
`define RTCC_ADDR_COMPCTL   8'h0D

// compensation control fields
`define RTCC_TSE_BIT        7
`define RTCC_BATSEL_HI      6
`define RTCC_BATSEL_LO      5
`define RTCC_STEP_MSB       4

// interrupt / frequency control fields
`define RTCC_FOUT_EN_BIT    7
`define RTCC_FSEL_MSB       2

// initial trim fields: digital on top, analog below
`define RTCC_IAT_MSB        5
`define RTCC_IDT_LSB        6

// reset values before the power-up recall
`define RTCC_INTCTL_RST     8'h00
`define RTCC_REG_RST        8'h00

// oscillator divider: bit 14 of a 15-bit count of 32 kHz edges toggles at 1 Hz
`define RTCC_OSC_HZ         32768
`define RTCC_DIV_W          15
`define RTCC_ONE_HZ_BIT     14

// compensation intervals in seconds
`define RTCC_SEC_W          10
`define RTCC_MAIN_PERIOD_S  10'h03C
`define RTCC_BAT1_PERIOD_S  10'h03C
`define RTCC_BAT2_PERIOD_S  10'h12C
`define RTCC_BAT3_PERIOD_S  10'h258

// serial address, value arbitrary
`define RTCC_DEV_ADDR       7'h52
// turnover temperature code
`define RTCC_T0_CODE        10'h0FA

`endif

// [rtl/rtcc_sync.v]
`default_nettype none

module rtcc_sync #(
   parameter WIDTH = 1
) (
   input  wire             i_clock,
   input  wire             i_reset_n,
   input  wire [WIDTH-1:0] i_async,
   output reg  [WIDTH-1:0] o_sync
);

   reg [WIDTH-1:0] meta_q;

   always @(posedge i_clock or negedge i_reset_n) begin
      if (!i_reset_n) begin
         meta_q <= {WIDTH{1'b0}};
         o_sync <= {WIDTH{1'b0}};
      end else begin
         meta_q <= i_async;
         o_sync <= meta_q;
      end
   end

endmodule // rtcc_sync

`default_nettype wire

// [dv/rtcc_ctrl_checker.sv]
`default_nettype none
module rtcc_ctrl_checker (
   input wire logic       i_clock,
   input wire logic       i_reset_n,
   input wire logic       i_scl,
   input wire logic       i_temp_valid,
   input wire logic [9:0] i_temp_code,
   input wire logic       o_sda_out,
   input wire logic       o_sda_oe,
   input wire logic       o_conv_start,
   input wire logic [5:0] o_final_analog_trim,
   input wire logic [2:0] o_final_digital_trim,
   input wire logic       o_irq_or_freq_out_pin_out
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [2:0] age_q;
   logic [9:0] last_q;
   logic       seen_q;
   logic       busy_q;
   wire  [8:0] trims = {o_final_digital_trim, o_final_analog_trim};
   default clocking cb @(posedge i_clock);
   endclocking
   default disable iff (!i_reset_n);
   // age after reset, last accepted code, conversion in flight
   always_ff @(posedge i_clock or negedge i_reset_n) begin
      if (!i_reset_n) begin
         age_q <= 3'h0;
         last_q <= 10'h000;
         seen_q <= 1'b0;
         busy_q <= 1'b0;
      end else begin
         if (age_q != 3'h7) age_q <= age_q + 3'h1;
         if (i_temp_valid && busy_q) begin
            last_q <= i_temp_code;
            seen_q <= 1'b1;
         end
         if (o_conv_start) busy_q <= 1'b1;
         else if (i_temp_valid) busy_q <= 1'b0;
      end
   end
   property p_reset_quiet;
      disable iff (1'b0) !i_reset_n |-> !o_conv_start && trims == 9'h000;
   endproperty
   a_reset_quiet: assert property (p_reset_quiet) else $error("output active in reset");
   property p_conv_pulse;
      o_conv_start |=> !o_conv_start;
   endproperty
   a_conv_pulse: assert property (p_conv_pulse) else $error("start pulse too long");
   property p_one_conv;
      busy_q |-> !o_conv_start;
   endproperty
   a_one_conv: assert property (p_one_conv) else $error("start while busy");
   property p_trim_cause;
      !$stable(trims) |-> $past(i_temp_valid, 2) || age_q != 3'h7;
   endproperty
   a_trim_cause: assert property (p_trim_cause) else $error("trim moved unprompted");
   property p_same_code;
      i_temp_valid && busy_q && seen_q && i_temp_code == last_q |=> $stable(trims)[*3];
   endproperty
   a_same_code: assert property (p_same_code) else $error("trim moved on same code");
   property p_sda_low;
      o_sda_out == 1'b0;
   endproperty
   a_sda_low: assert property (p_sda_low) else $error("data pin driven high");
   property p_fout_low;
      o_irq_or_freq_out_pin_out == 1'b0;
   endproperty
   a_fout_low: assert property (p_fout_low) else $error("fout pin driven high");
   property p_ack_scl;
      $changed(o_sda_oe) |-> !i_scl;
   endproperty
   a_ack_scl: assert property (p_ack_scl) else $error("data moved with clock high");
endmodule // rtcc_ctrl_checker
bind rtcc_ctrl rtcc_ctrl_checker rtcc_ctrl_checker_inst (
   .i_clock(i_clock), .i_reset_n(i_reset_n), .i_scl(i_scl),
   .i_temp_valid(i_temp_valid), .i_temp_code(i_temp_code),
   .o_sda_out(o_sda_out), .o_sda_oe(o_sda_oe), .o_conv_start(o_conv_start),
   .o_final_analog_trim(o_final_analog_trim),
   .o_final_digital_trim(o_final_digital_trim), .o_irq_or_freq_out_pin_out(o_irq_or_freq_out_pin_out)
);
`default_nettype wire

// [dv/rtcc_host_model.sv]
`include "rtcc_defs.vh"
`default_nettype none
module rtcc_host_model (
   input  wire logic i_clock,
   input  wire logic i_sda,
   output var  logic o_scl,
   output var  logic o_sda_oe
);
   timeunit 1ns;
   timeprecision 1ps;
   int         nack_count = 0;
   logic [7:0] junk;
   initial begin
      o_scl = 1'b1;
      o_sda_oe = 1'b0;
   end
   task automatic tick(input int n);
      repeat (n) @(negedge i_clock);
   endtask
   task automatic bit_io(input logic b, output logic r);
      o_sda_oe = ~b;
      tick(4);
      o_scl = 1'b1;
      tick(8);
      r = i_sda;
      o_scl = 1'b0;
      tick(4);
   endtask
   // start from idle or repeated start with clock low
   task automatic start_cond();
      o_sda_oe = 1'b0;
      tick(4);
      o_scl = 1'b1;
      tick(8);
      o_sda_oe = 1'b1;
      tick(8);
      o_scl = 1'b0;
      tick(4);
   endtask
   task automatic stop_cond();
      o_sda_oe = 1'b1;
      tick(4);
      o_scl = 1'b1;
      tick(8);
      o_sda_oe = 1'b0;
      tick(8);
   endtask
   task automatic byte_io(input logic [7:0] tx, input logic is_rd, output logic [7:0] rx);
      logic a;
      for (int i = 7; i >= 0; i--) bit_io(tx[i], rx[i]);
      bit_io(1'b1, a);
      if (!is_rd && a !== 1'b0) nack_count++;
   endtask
   task automatic reg_write(input logic [7:0] addr, input logic [7:0] data);
      start_cond();
      byte_io({`RTCC_DEV_ADDR, 1'b0}, 1'b0, junk);
      byte_io(addr, 1'b0, junk);
      byte_io(data, 1'b0, junk);
      stop_cond();
   endtask
   task automatic reg_read(input logic [7:0] addr, output logic [7:0] data);
      start_cond();
      byte_io({`RTCC_DEV_ADDR, 1'b0}, 1'b0, junk);
      byte_io(addr, 1'b0, junk);
      start_cond();
      byte_io({`RTCC_DEV_ADDR, 1'b1}, 1'b0, junk);
      byte_io(8'hFF, 1'b1, data);
      stop_cond();
   endtask
endmodule // rtcc_host_model
`default_nettype wire

// [dv/test_rtc_temp_comp_control.sv]
`include "rtcc_defs.vh"
`default_nettype none
module test_rtc_temp_comp_control;
   timeunit 1ns;
   timeprecision 1ps;
   logic       clk = 1'b0;
   logic       rst_n = 1'b1;
   logic       osc = 1'b0;
   logic       batt = 1'b0;
   logic       tvalid = 1'b0;
   logic [9:0] tcode = 10'h000;
   logic [4:0] step = 5'h00;
   logic [7:0] itrim = 8'h00;
   logic [7:0] curv = 8'h00;
   logic [7:0] rd;
   wire        scl;
   wire        h_oe;
   wire        d_oe;
   wire        conv;
   wire        f_oe;
   wire  [5:0] fa;
   wire  [2:0] fd;
   wire        sda = ~(h_oe | d_oe);
   int         err_count = 0;
   int         checks_done = 0;
   int         n_conv = 0;
   int         e_conv = 0;
   int         prev = -1;
   int         base;
   int         e_trim;
   rtcc_ctrl rtcc_ctrl_inst (
      .i_clock(clk), .i_reset_n(rst_n), .i_scl(scl), .i_sda(sda), .o_sda_out(),
      .o_sda_oe(d_oe), .i_osc_32k(osc), .i_battery_mode(batt),
      .i_factory_step_trim(step), .i_factory_initial_trim(itrim),
      .i_factory_curvature(curv), .i_temp_valid(tvalid), .i_temp_code(tcode),
      .o_conv_start(conv), .o_final_analog_trim(fa), .o_final_digital_trim(fd),
      .o_irq_or_freq_out_pin_out(), .o_irq_or_freq_out_pin_oe(f_oe)
   );
   rtcc_host_model rtcc_host_model_inst (
      .i_clock(clk), .i_sda(sda), .o_scl(scl), .o_sda_oe(h_oe)
   );
   initial forever #5 clk = ~clk;
   initial forever #40 osc = ~osc;
   always @(posedge clk) if (conv === 1'b1) n_conv++;
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      checks_done++;
      if (seen !== exp) begin
         err_count++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic conclude();
      $display("checks %0d errors %0d", checks_done, err_count);
      if (err_count == 0 && checks_done > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      rtcc_host_model_inst.reg_write(a, d);
   endtask
   task automatic rr(input logic [7:0] a);
      rtcc_host_model_inst.reg_read(a, rd);
   endtask
   // sensor answer and reference trim arithmetic
   task automatic convert(input int code);
      int d;
      d = code - 250;
      if (d < 0) d = -d;
      @(negedge clk);
      tvalid = 1'b1;
      tcode = code[9:0];
      @(negedge clk);
      tvalid = 1'b0;
      repeat (4) @(negedge clk);
      if (code != prev) e_trim = base - ((((d * d * int'(curv)) >> 20) * int'(step)) >> 4);
      if (e_trim < 0) e_trim = 0;
      prev = code;
      check({fd, fa}, e_trim[8:0]);
   endtask
   task automatic comp_on(input logic [1:0] mode, input int code);
      rr(`RTCC_ADDR_COMPCTL);
      wr(`RTCC_ADDR_COMPCTL, {1'b1, mode, rd[4:0]});
      e_conv++;
      check(n_conv, e_conv);
      convert(code);
      rr(`RTCC_ADDR_COMPCTL);
      check(rd, {1'b1, mode, step});
   endtask
   task automatic fout(input logic [2:0] sel, input int per);
      int n;
      wr(`RTCC_ADDR_INTCTL, {5'h10, sel});
      for (int k = 0; k < 2; k++) begin
         n = 1;
         @(negedge clk);
         for (; f_oe !== 1'b0 && n < 20000; n++) @(negedge clk);
         for (; f_oe !== 1'b1 && n < 20000; n++) @(negedge clk);
      end
      check(n, per);
   endtask
   initial begin
      #1000000;
      err_count++;
      conclude();
   end
   initial begin
      int n;
      void'($urandom(49));
      batt = 1'($urandom);
      step = 5'($urandom);
      itrim = 8'($urandom);
      curv = 8'($urandom);
      base = itrim;
      e_trim = itrim;
      // real falling edge, so reset acts before the first clock
      #2 rst_n = 1'b0;
      repeat (12) @(negedge clk);
      rst_n = 1'b1;
      repeat (8) @(negedge clk);
      check({fd, fa}, itrim);
      rr(`RTCC_ADDR_COMPCTL);
      check(rd, {3'h0, step});
      rr(`RTCC_ADDR_INITRIM);
      check(rd, itrim);
      rr(`RTCC_ADDR_CURVE);
      check(rd, curv);
      rr(8'h10);
      check(rd, 8'h00);
      check(n_conv, 0);
      for (int m = 0; m < 4; m++) comp_on(2'(m), m == 1 ? prev : int'(10'($urandom)));
      wr(`RTCC_ADDR_COMPCTL, {3'h1, step});
      check(n_conv, e_conv);
      base = 8'(itrim + 8'h10);
      wr(`RTCC_ADDR_INITRIM, 8'(base));
      comp_on(2'h2, prev ^ 1);
      wr(`RTCC_ADDR_INITRIM, itrim);
      rr(`RTCC_ADDR_INITRIM);
      check(rd, itrim);
      fout(3'h7, 2048);
      fout(3'h5, 8192);
      wr(`RTCC_ADDR_INTCTL, 8'h05);
      n = 0;
      repeat (9000) begin
         @(negedge clk);
         if (f_oe !== 1'b0) n++;
      end
      check(n, 0);
      check(rtcc_host_model_inst.nack_count, 0);
      conclude();
   end
endmodule // test_rtc_temp_comp_control
`default_nettype wire
